// ### rsc_reset_source_controller.sv
// Reset source controller: gathers reset requests, sequences release, keeps cause flags.
`timescale 1ns/1ps
`default_nettype none

module rsc_reset_source_controller
	import rsc_pkg::*;
#(
	parameter int unsigned SUPPLY_CYC = RSC_SUPPLY_TIMEOUT_CYC,
	parameter int unsigned MCD_CYC = RSC_MCD_TIMEOUT_CYC
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire rsc_apb_req_t apb_req,
	output var rsc_apb_rsp_t apb_rsp,
	input wire logic supply_ok,
	input wire logic supply_monitor_enable,
	input wire logic rst_pin_in,
	output var logic rst_pin_out,
	output var logic rst_pin_oe_n,
	input wire logic comparator_below,
	input wire logic watchdog_overflow,
	input wire logic sysclk_toggle,
	input wire logic sysclk_stable,
	output var rsc_core_ctl_t core_ctl
);

	// Power-on is the only cause presetn can stand for, so the sequence restarts
	// with the pin driven and the core held.
	localparam rsc_regs_t RSC_REGS_RESET = '{
		st: RSC_HOLD,
		sy1: RSC_SYNC_RESET,
		sy2: RSC_SYNC_RESET,
		sy3: RSC_SYNC_RESET,
		flt: RSC_SYNC_RESET,
		cause: RSC_CAUSE_POR,
		ctl: '{
			pc_value: RSC_RESET_VECTOR,
			port_value: RSC_PORT_RESET,
			wdt_interval: RSC_WDT_INTERVAL_RESET,
			sp_reinit: 1'b1,
			port_load: 1'b1,
			pullup_en: 1'b1,
			osc_internal: 1'b1,
			wdt_restart: 1'b1,
			default: '0
		},
		default: '0
	};

	rsc_regs_t r;
	rsc_regs_t n;
	logic por_lvl;
	logic pin_lvl;
	logic cmp_lvl;
	logic hold_lvl;
	logic mcd_evt;
	logic [5:0] req;
	logic acc;
	logic mapped;
	logic [31:0] rd;
	logic in_rst;

	always_comb
	begin
		n = r;
		mcd_evt = 1'b0;

		// The third flop only feeds the filter, so a one-sample glitch never
		// reaches the sequencer.
		// three-stage synchronisers
		n.sy1[RSC_SY_SUPPLY] = supply_ok;
		n.sy1[RSC_SY_SUPPLY_MONITOR_ENABLE] = supply_monitor_enable;
		n.sy1[RSC_SY_PIN] = rst_pin_in;
		n.sy1[RSC_SY_CMP] = comparator_below;
		n.sy1[RSC_SY_CLKOK] = sysclk_stable;
		n.sy1[RSC_SY_SYSCLK] = sysclk_toggle;
		n.sy2 = r.sy1;
		n.sy3 = r.sy2;
		// accept a change once stages agree
		for (int i = 0; i < RSC_SY_N; i++)
		begin
			if (r.sy2[i] == r.sy3[i])
			begin
				n.flt[i] = r.sy2[i];
			end
		end

		por_lvl = r.flt[RSC_SY_SUPPLY_MONITOR_ENABLE] & ~r.flt[RSC_SY_SUPPLY];
		// Without the mask our own power-on drive would read back as a pin
		// reset, and the hold would never end.
		// pin low is a source, masked while we drive it
		pin_lvl = ~r.flt[RSC_SY_PIN] & ~r.cause[RSC_BIT_POR];
		cmp_lvl = r.cmp_en & r.flt[RSC_SY_CMP];
		// Level sources keep the hold; event sources only enter it.
		hold_lvl = por_lvl | pin_lvl | cmp_lvl;

		// The toggle is filtered like any pin, so the timeout must span several
		// toggle periods; a short setting trips on a healthy but slow clock.
		// one-shot retriggered by each system clock edge
		n.mcd_prev = r.flt[RSC_SY_SYSCLK];
		if (r.cld_en && r.st == RSC_RUN)
		begin
			if (r.flt[RSC_SY_SYSCLK] != r.mcd_prev)
			begin
				n.mcd_cnt = '0;
			end
			else if (r.mcd_cnt == RSC_MCD_W'(MCD_CYC - 1))
			begin
				mcd_evt = 1'b1;
				n.mcd_cnt = '0;
			end
			else
			begin
				n.mcd_cnt = r.mcd_cnt + 1'b1;
			end
		end
		else
		begin
			n.mcd_cnt = '0;
		end

		req = '0;
		// forced POR merges with the supply request
		req[RSC_BIT_POR] = por_lvl | r.sw_por;
		req[RSC_BIT_PIN] = pin_lvl;
		req[RSC_BIT_MCD] = mcd_evt;
		// watchdog overflow is an internal reset
		req[RSC_BIT_WDT] = watchdog_overflow;
		// software reset is an internal reset
		req[RSC_BIT_SW] = r.sw_soft;
		req[RSC_BIT_CMP] = cmp_lvl;

		// Software forces are one-cycle pulses; a level would re-enter reset
		// straight after release.
		n.sw_por = 1'b0;
		n.sw_soft = 1'b0;

		// Power-on overrides any earlier cause; else lowest bit wins on entry.
		// A one-hot cause keeps each flag meaningful when two sources strike
		// together; the lower-ranked request is dropped, not queued.
		if (req[RSC_BIT_POR])
		begin
			n.cause = RSC_CAUSE_POR;
		end
		else if (r.st == RSC_RUN && req != '0)
		begin
			n.cause = '0;
			if (req[RSC_BIT_PIN])
			begin
				n.cause[RSC_BIT_PIN] = 1'b1;
			end
			else if (req[RSC_BIT_MCD])
			begin
				n.cause[RSC_BIT_MCD] = 1'b1;
			end
			else if (req[RSC_BIT_WDT])
			begin
				n.cause[RSC_BIT_WDT] = 1'b1;
			end
			else if (req[RSC_BIT_SW])
			begin
				n.cause[RSC_BIT_SW] = 1'b1;
			end
			else
			begin
				n.cause[RSC_BIT_CMP] = 1'b1;
			end
		end

		unique case (r.st)
			RSC_RUN:
			begin
				if (req != '0)
				begin
					n.st = RSC_HOLD;
				end
			end
			RSC_HOLD:
			begin
				// stay held until the supply, pin and comparator requests are all clear
				if (!hold_lvl && !req[RSC_BIT_POR])
				begin
					n.st = RSC_STRETCH;
					// A power-on cause takes the long count even with the monitor
					// strapped off, so a forced power-on still lets the board settle.
					// supply timeout or pin stretch
					if (r.cause[RSC_BIT_POR])
					begin
						n.tmr = RSC_TMR_W'(SUPPLY_CYC - 1);
					end
					else
					begin
						n.tmr = RSC_TMR_W'(RSC_PIN_STRETCH_CYC - 1);
					end
				end
			end
			RSC_STRETCH:
			begin
				// a renewed drop restarts the sequence
				if (hold_lvl || req[RSC_BIT_POR])
				begin
					n.st = RSC_HOLD;
				end
				else if (r.tmr == '0)
				begin
					n.st = RSC_WAITCLK;
				end
				else
				begin
					n.tmr = r.tmr - 1'b1;
				end
			end
			RSC_WAITCLK:
			begin
				if (hold_lvl || req[RSC_BIT_POR])
				begin
					n.st = RSC_HOLD;
				end
				// Waiting on the pin too lets an outside supervisor that holds the
				// line low extend our reset without a second cause.
				// release only with a stable clock
				else if (r.flt[RSC_SY_CLKOK] && r.flt[RSC_SY_PIN])
				begin
					n.st = RSC_RUN;
					n.flags = r.cause;
					n.cause = '0;
					n.cmp_en = 1'b0;
					n.cld_en = 1'b0;
				end
			end
		endcase

		in_rst = (n.st != RSC_RUN);
		// core held, SFRs and timers preset
		n.ctl.core_reset_n = ~in_rst;
		// one-cycle load of the reset vector
		n.ctl.pc_clear = (r.st == RSC_WAITCLK) && (n.st == RSC_RUN);
		n.ctl.pc_value = RSC_RESET_VECTOR;
		// only the stack pointer, data memory untouched
		n.ctl.sp_reinit = in_rst;
		// port latches to ones, pull-ups always on
		n.ctl.port_load = in_rst;
		n.ctl.port_value = RSC_PORT_RESET;
		n.ctl.pullup_en = 1'b1;
		// internal oscillator, watchdog restarted at longest
		n.ctl.osc_internal = in_rst;
		n.ctl.wdt_restart = in_rst;
		n.ctl.wdt_interval = RSC_WDT_INTERVAL_RESET;

		// drive the pin low only for power-on causes
		n.pin_out = 1'b0;
		// other causes leave pin undriven
		// The driver lets go as the stretch ends, so the pin is back high
		// before the clock wait checks it.
		n.pin_oe_n = ~(n.cause[RSC_BIT_POR] && (n.st == RSC_HOLD || n.st == RSC_STRETCH));

		acc = apb_req.psel & apb_req.penable;
		rd = '0;
		mapped = 1'b1;
		unique case (apb_req.paddr)
			RSC_ADDR_SRC:
			begin
				// comparator bit reads its cause flag
				rd[5:0] = r.flags;
			end
			RSC_ADDR_OSC:
			begin
				rd[RSC_BIT_CLD] = r.cld_en;
			end
			RSC_ADDR_STAT:
			begin
				rd[0] = r.flt[RSC_SY_SUPPLY_MONITOR_ENABLE];
				rd[1] = r.flt[RSC_SY_SUPPLY];
				rd[2] = r.flt[RSC_SY_CLKOK];
				rd[5:4] = r.st;
			end
			default:
			begin
				mapped = 1'b0;
			end
		endcase

		// One wait state keeps every response field straight from a flop.
		if (acc && !r.rsp.pready)
		begin
			n.rsp.pready = 1'b1;
			n.rsp.pslverr = ~mapped;
			n.rsp.prdata = apb_req.pwrite ? 32'h0000_0000 : rd;
		end
		else
		begin
			n.rsp.pready = 1'b0;
			n.rsp.pslverr = 1'b0;
			n.rsp.prdata = 32'h0000_0000;
		end

		// Writes land on the completing edge and after release, so they win.
		if (acc && r.rsp.pready && apb_req.pwrite)
		begin
			if (apb_req.paddr == RSC_ADDR_SRC)
			begin
				// write of one forces power-on reset
				n.sw_por = apb_req.pwdata[RSC_BIT_POR];
				// write of one forces software reset
				n.sw_soft = apb_req.pwdata[RSC_BIT_SW];
				n.cmp_en = apb_req.pwdata[RSC_BIT_CMP];
			end
			else if (apb_req.paddr == RSC_ADDR_OSC)
			begin
				n.cld_en = apb_req.pwdata[RSC_BIT_CLD];
			end
		end
	end

	// State and outputs share one register, so every port comes straight off a flop.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r <= RSC_REGS_RESET;
		end
		else
		begin
			r <= n;
		end
	end

	assign apb_rsp = r.rsp;
	assign core_ctl = r.ctl;
	assign rst_pin_out = r.pin_out;
	assign rst_pin_oe_n = r.pin_oe_n;

endmodule

`default_nettype wire

// ### rsc_pkg.sv
// Constants, carriers and state types shared by the reset source controller.
package rsc_pkg;

	localparam int unsigned RSC_CLK_MHZ = 50;
	localparam int unsigned RSC_SUPPLY_TIMEOUT_US = 100000;
	localparam int unsigned RSC_SUPPLY_TIMEOUT_CYC = RSC_SUPPLY_TIMEOUT_US * RSC_CLK_MHZ;
	localparam int unsigned RSC_MCD_TIMEOUT_US = 100;
	localparam int unsigned RSC_MCD_TIMEOUT_CYC = RSC_MCD_TIMEOUT_US * RSC_CLK_MHZ;
	localparam int unsigned RSC_PIN_STRETCH_CYC = 12;
	localparam int unsigned RSC_TMR_W = 23;
	localparam int unsigned RSC_MCD_W = 16;

	localparam logic [7:0] RSC_ADDR_SRC = 8'h00;
	localparam logic [7:0] RSC_ADDR_OSC = 8'h04;
	localparam logic [7:0] RSC_ADDR_STAT = 8'h08;

	localparam int RSC_BIT_PIN = 0;
	localparam int RSC_BIT_POR = 1;
	localparam int RSC_BIT_MCD = 2;
	localparam int RSC_BIT_WDT = 3;
	localparam int RSC_BIT_SW = 4;
	localparam int RSC_BIT_CMP = 5;
	localparam int RSC_BIT_CLD = 7;

	localparam int RSC_SY_SUPPLY = 0;
	localparam int RSC_SY_SUPPLY_MONITOR_ENABLE = 1;
	localparam int RSC_SY_PIN = 2;
	localparam int RSC_SY_CMP = 3;
	localparam int RSC_SY_CLKOK = 4;
	localparam int RSC_SY_SYSCLK = 5;
	localparam int RSC_SY_N = 6;

	localparam logic [5:0] RSC_SYNC_RESET = 6'h04;
	localparam logic [5:0] RSC_CAUSE_POR = 6'h02;
	localparam logic [7:0] RSC_PORT_RESET = 8'hff;
	localparam logic [15:0] RSC_RESET_VECTOR = 16'h0000;
	localparam logic [2:0] RSC_WDT_INTERVAL_RESET = 3'h7;

	typedef enum logic [1:0] {
		RSC_RUN = 2'b00,
		RSC_HOLD = 2'b01,
		RSC_STRETCH = 2'b10,
		RSC_WAITCLK = 2'b11
	} rsc_state_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} rsc_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} rsc_apb_rsp_t;

	typedef struct packed {
		logic core_reset_n;
		logic pc_clear;
		logic [15:0] pc_value;
		logic sp_reinit;
		logic port_load;
		logic [7:0] port_value;
		logic pullup_en;
		logic osc_internal;
		logic wdt_restart;
		logic [2:0] wdt_interval;
	} rsc_core_ctl_t;

	typedef struct packed {
		rsc_state_t st;
		logic [5:0] sy1;
		logic [5:0] sy2;
		logic [5:0] sy3;
		logic [5:0] flt;
		logic mcd_prev;
		logic [RSC_MCD_W-1:0] mcd_cnt;
		logic [RSC_TMR_W-1:0] tmr;
		logic [5:0] cause;
		logic [5:0] flags;
		logic cmp_en;
		logic cld_en;
		logic sw_por;
		logic sw_soft;
		logic pin_out;
		logic pin_oe_n;
		rsc_apb_rsp_t rsp;
		rsc_core_ctl_t ctl;
	} rsc_regs_t;

endpackage

// ### rsc_placeholder_unused.sv
// Intentionally empty compile unit kept out: no further design content.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### rsc_checker.sv
// Checker of reset sequencing and core control at the controller ports.
`timescale 1ns/1ps
`default_nettype none
module rsc_checker
	import rsc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire rsc_apb_req_t apb_req,
	input wire rsc_apb_rsp_t apb_rsp,
	input wire logic supply_ok,
	input wire logic supply_monitor_enable,
	input wire logic rst_pin_in,
	input wire logic rst_pin_out,
	input wire logic rst_pin_oe_n,
	input wire logic comparator_below,
	input wire logic watchdog_overflow,
	input wire logic sysclk_toggle,
	input wire logic sysclk_stable,
	input wire rsc_core_ctl_t core_ctl
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_pc;
		core_ctl.pc_clear |-> $rose(core_ctl.core_reset_n) && core_ctl.pc_value == 16'h0000;
	endproperty
	a_pc: assert property (p_pc) else $error("pc clear out of place");
	property p_hold;
		!core_ctl.core_reset_n |-> core_ctl.port_load && core_ctl.sp_reinit
			&& core_ctl.osc_internal && core_ctl.wdt_restart && core_ctl.wdt_interval == 3'h7;
	endproperty
	a_hold: assert property (p_hold) else $error("reset presets missing");
	property p_port;
		core_ctl.port_value == 8'hff && core_ctl.pullup_en;
	endproperty
	a_port: assert property (p_port) else $error("port preset wrong");
	property p_drive;
		!rst_pin_oe_n |-> !core_ctl.core_reset_n && !rst_pin_out;
	endproperty
	a_drive: assert property (p_drive) else $error("pin driven outside reset");
	property p_run;
		$rose(core_ctl.core_reset_n) |-> sysclk_stable && rst_pin_in;
	endproperty
	a_run: assert property (p_run) else $error("release before clock stable");
	property p_wdt;
		watchdog_overflow && core_ctl.core_reset_n |=> !core_ctl.core_reset_n && rst_pin_oe_n;
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog reset wrong");
	property p_supply;
		supply_monitor_enable && $fell(supply_ok) |-> ##[1:8] !rst_pin_oe_n;
	endproperty
	a_supply: assert property (p_supply) else $error("supply drop not seen");
	// Pin releases by the device itself are excluded, they end a power-on reset.
	property p_stretch;
		$rose(rst_pin_in) && $past(rst_pin_oe_n) |->
			(!core_ctl.core_reset_n) [*8] ##1 (!core_ctl.core_reset_n) [*5];
	endproperty
	a_stretch: assert property (p_stretch) else $error("pin stretch short");
endmodule
bind rsc_reset_source_controller rsc_checker u_chk(.pclk(pclk), .presetn(presetn),
	.apb_req(apb_req), .apb_rsp(apb_rsp), .supply_ok(supply_ok),
	.supply_monitor_enable(supply_monitor_enable), .rst_pin_in(rst_pin_in),
	.rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n),
	.comparator_below(comparator_below), .watchdog_overflow(watchdog_overflow),
	.sysclk_toggle(sysclk_toggle), .sysclk_stable(sysclk_stable), .core_ctl(core_ctl));
`default_nettype wire

// ### rsc_far_model.sv
// Far-side model: system clock activity and the resolved reset pin.
`timescale 1ns/1ps
`default_nettype none
module rsc_far_model
(
	input wire logic pclk,
	input wire logic clk_on,
	input wire logic ext_low,
	input wire logic rst_pin_out,
	input wire logic rst_pin_oe_n,
	output var logic sysclk_toggle,
	output wire logic sysclk_stable,
	output wire logic rst_pin_in
);
	logic [1:0] div_r;
	initial sysclk_toggle = 1'b0;
	initial div_r = 2'h0;
	// The toggle moves every fourth edge so that the three-flop filter can follow it.
	// A stopped clock leaves the toggle frozen, so the detector sees no edge.
	always @(posedge pclk)
	begin
		if (clk_on)
		begin
			div_r <= div_r + 2'h1;
			if (div_r == 2'h3)
			begin
				sysclk_toggle <= ~sysclk_toggle;
			end
		end
	end
	assign sysclk_stable = clk_on;
	assign rst_pin_in = ~ext_low & (rst_pin_oe_n | rst_pin_out);
endmodule
`default_nettype wire

// ### rsc_reset_source_controller_test.sv
// Self-checking testbench of the reset source controller.
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_source_controller_test;
	import rsc_pkg::*;
	logic pclk, presetn, sup, mon, cmpb, wdo, clk_on, ext, pin_in, pin_out, pin_oe_n, tog, stab;
	rsc_apb_req_t req;
	rsc_apb_rsp_t rsp;
	rsc_core_ctl_t ctl;
	int n_fail, n_compared;
	rsc_reset_source_controller #(.SUPPLY_CYC(20), .MCD_CYC(16)) u_dut(.pclk(pclk),
		.presetn(presetn), .apb_req(req), .apb_rsp(rsp), .supply_ok(sup),
		.supply_monitor_enable(mon), .rst_pin_in(pin_in), .rst_pin_out(pin_out),
		.rst_pin_oe_n(pin_oe_n), .comparator_below(cmpb), .watchdog_overflow(wdo),
		.sysclk_toggle(tog), .sysclk_stable(stab), .core_ctl(ctl));
	rsc_far_model u_far(.pclk(pclk), .clk_on(clk_on), .ext_low(ext), .rst_pin_out(pin_out),
		.rst_pin_oe_n(pin_oe_n), .sysclk_toggle(tog), .sysclk_stable(stab), .rst_pin_in(pin_in));
	always #10 pclk = ~pclk;
	task automatic tally_and_finish;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic lim(input int i);
		if (i >= 300)
		begin
			n_fail++;
			$display("BAD %0t wait ran out", $time);
			tally_and_finish;
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int i;
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge pclk);
		req.penable <= 1'b1;
		i = 0;
		do
		begin
			@(posedge pclk);
			i++;
		end
		while (rsp.pready !== 1'b1 && i < 300);
		lim(i);
		q = rsp.prdata;
		e = rsp.pslverr;
		req <= '0;
		@(posedge pclk);
	endtask
	// Whole-word writes only, never read-modify-write of the source register.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic wait_rst(input logic v);
		int i;
		i = 0;
		while (ctl.core_reset_n !== v && i < 300)
		begin
			@(posedge pclk);
			i++;
		end
		lim(i);
	endtask
	task automatic enter(input logic oe);
		wait_rst(1'b0);
		@(posedge pclk);
		chk(32'(pin_oe_n), 32'(oe));
	endtask
	task automatic leave(input logic [31:0] exp, input string name);
		logic [31:0] q;
		logic e;
		wait_rst(1'b1);
		apb(1'b0, 8'h00, 32'h0, q, e);
		chk(q, exp);
		$display("test %s done", name);
	endtask
	task automatic t_pin;
		ext <= 1'b1;
		enter(1'b1);
		ext <= 1'b0;
		leave(32'h01, "pin");
	endtask
	task automatic t_wdt;
		wdo <= 1'b1;
		@(posedge pclk);
		wdo <= 1'b0;
		enter(1'b1);
		leave(32'h08, "watchdog");
	endtask
	task automatic t_cmp;
		// comparator output settles before its reset enable.
		cmpb <= 1'b1;
		repeat (8) @(posedge pclk);
		chk(32'(ctl.core_reset_n), 32'h1);
		wr(8'h00, 32'h20);
		enter(1'b1);
		cmpb <= 1'b0;
		leave(32'h20, "comparator");
	endtask
	task automatic t_mcd;
		logic [31:0] q;
		logic e;
		clk_on <= 1'b0;
		repeat (40) @(posedge pclk);
		chk(32'(ctl.core_reset_n), 32'h1);
		clk_on <= 1'b1;
		wr(8'h04, 32'h80);
		apb(1'b0, 8'h04, 32'h0, q, e);
		chk(q, 32'h80);
		repeat (40) @(posedge pclk);
		chk(32'(ctl.core_reset_n), 32'h1);
		clk_on <= 1'b0;
		enter(1'b1);
		clk_on <= 1'b1;
		leave(32'h04, "clock loss");
	endtask
	task automatic t_bad;
		logic [31:0] q;
		logic e;
		apb(1'b0, 8'h0c, 32'h0, q, e);
		chk(32'(e), 32'h1);
		apb(1'b0, 8'h08, 32'h0, q, e);
		chk(q, 32'h07);
		chk(32'(e), 32'h0);
		$display("test unmapped done");
	endtask
	task automatic t_por;
		enter(1'b0);
		leave(32'h02, "power-on");
	endtask
	task automatic t_sw;
		wr(8'h00, 32'h10);
		enter(1'b1);
		leave(32'h10, "software");
	endtask
	task automatic t_fpor;
		wr(8'h00, 32'h02);
		enter(1'b0);
		leave(32'h02, "forced power-on");
	endtask
	task automatic t_sup;
		sup <= 1'b0;
		enter(1'b0);
		sup <= 1'b1;
		leave(32'h02, "supply drop");
	endtask
	task automatic t_mon;
		{mon, sup} <= 2'b00;
		repeat (12) @(posedge pclk);
		chk(32'(ctl.core_reset_n), 32'h1);
		{mon, sup} <= 2'b11;
		repeat (6) @(posedge pclk);
		$display("test monitor off done");
	endtask
	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		req = '0;
		{sup, mon, clk_on} = 3'b111;
		{cmpb, wdo, ext} = 3'b000;
		n_fail = 0;
		n_compared = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_por;
		t_pin;
		t_wdt;
		t_sw;
		t_cmp;
		t_mcd;
		t_fpor;
		t_sup;
		t_mon;
		t_bad;
		tally_and_finish;
	end
endmodule
`default_nettype wire
